// File: asq_seq_ctrl.sv
// Purpose: sample sequence control and result FIFOs behind an AXI4-Lite slave
// Assumes: converter and external result sources share core_clk
// Notes: sequencers 0 and 3 are run here; 1 and 2 are filled from the ext port
`timescale 1ns/100ps
module asq_seq_ctrl #(
    parameter int FIFO_DEPTH = asq_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // axi4-lite write address
    input wire logic [asq_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [asq_pkg::BUS_W-1:0] wdata,
    input wire logic [asq_pkg::STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [asq_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [asq_pkg::BUS_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // converter
    output asq_pkg::asq_conv_s convCmd,
    output logic convReq,
    input wire logic convDone,
    input wire logic [asq_pkg::RES_W-1:0] convData,
    // results of sequencers 1 and 2
    input wire logic extValid,
    input wire logic [1:0] extSeq,
    input wire logic [asq_pkg::RES_W-1:0] extData,
    // events
    output logic [asq_pkg::NUM_SEQ-1:0] rawIrq,
    output logic [asq_pkg::NUM_SEQ-1:0] ovfFlags,
    output logic [asq_pkg::NUM_SEQ-1:0] unfFlags
);
    localparam int NS = asq_pkg::NUM_SEQ;
    localparam int IW = $clog2(FIFO_DEPTH);
    localparam int PW = asq_pkg::PTR_W;
    localparam int BW = asq_pkg::BUS_W;
    localparam int RW = asq_pkg::RES_W;

    if (FIFO_DEPTH < 2 || IW > PW || (1 << IW) != FIFO_DEPTH) begin : gBadDepth
        $error("asq_seq_ctrl: FIFO_DEPTH must be a power of two that fits the pointer fields");
    end

    function automatic logic hitOff(input logic [asq_pkg::ADDR_W-1:0] a,
                                    input logic [asq_pkg::ADDR_W-1:0] off);
        hitOff = (a[asq_pkg::ADDR_W-1:2] == off[asq_pkg::ADDR_W-1:2]);
    endfunction

    function automatic logic [BW-1:0] strbMerge(input logic [BW-1:0] oldV,
                                                input logic [BW-1:0] newV,
                                                input logic [asq_pkg::STRB_W-1:0] strb);
        logic [BW-1:0] res;
        res = oldV;
        for (int i = 0; i < asq_pkg::STRB_W; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = newV[8*i +: 8];
            end
        end
        strbMerge = res;
    endfunction

    function automatic logic [BW-1:0] statWord(input logic isFull, input logic isEmpty,
                                               input logic [PW-1:0] wr,
                                               input logic [PW-1:0] rd);
        logic [BW-1:0] w;
        w = '0;
        w[asq_pkg::STAT_FULL_BIT] = isFull;
        w[asq_pkg::STAT_EMPTY_BIT] = isEmpty;
        w[asq_pkg::STAT_WR_LSB +: PW] = wr;
        w[asq_pkg::STAT_RD_LSB +: PW] = rd;
        statWord = w;
    endfunction

    // write path: address and data held until both are in
    logic awHave_r, wHave_r, bvalid_r, awready_r, wready_r;
    logic [asq_pkg::ADDR_W-1:0] wrAddr_r;
    logic [BW-1:0] wrData_r;
    logic [asq_pkg::STRB_W-1:0] wrStrb_r;
    logic [1:0] bresp_r;
    logic awTake, wTake, doWrite, awHaveNxt, wHaveNxt;
    assign awTake = awvalid & awready_r;
    assign wTake = wvalid & wready_r;
    assign doWrite = awHave_r & wHave_r & ~bvalid_r;
    assign awHaveNxt = (awHave_r & ~doWrite) | awTake;
    assign wHaveNxt = (wHave_r & ~doWrite) | wTake;

    logic wrCtl0, wrSeq3, wrOvf, wrUnf, wrTrig, wrHit;
    logic [NS-1:0] lowByte;
    assign wrCtl0 = doWrite & hitOff(wrAddr_r, asq_pkg::OFF_SEQ0_CTL);
    assign wrSeq3 = doWrite & hitOff(wrAddr_r, asq_pkg::OFF_SEQ3_CTL);
    assign wrOvf = doWrite & hitOff(wrAddr_r, asq_pkg::OFF_OVF);
    assign wrUnf = doWrite & hitOff(wrAddr_r, asq_pkg::OFF_UNF);
    assign wrTrig = doWrite & hitOff(wrAddr_r, asq_pkg::OFF_TRIG);
    assign lowByte = wrStrb_r[0] ? wrData_r[NS-1:0] : '0;

    // read path: one read open at a time
    logic arready_r, rvalid_r, arTake, rvalidNxt;
    logic [BW-1:0] rdata_r;
    logic [1:0] rresp_r;
    assign arTake = arvalid & arready_r;
    assign rvalidNxt = arTake | (rvalid_r & ~rready);

    // control registers
    logic [BW-1:0] ctl0_r;
    logic [3:0] seq3Ctl_r;
    logic [NS-1:0] ovf_r, unf_r, pending_r;
    asq_pkg::asq_nibble_s [asq_pkg::NUM_SAMPLES-1:0] ctl0Nibs;
    asq_pkg::asq_nibble_s seq3Nib;
    assign ctl0Nibs = ctl0_r;
    assign seq3Nib = {seq3Ctl_r[3:2], 1'b1, seq3Ctl_r[0]};

    // result fifos
    logic [NS-1:0] fifoInValid, fifoInReady, fifoOutValid, fifoOutReady, fifoFull, fifoEmpty;
    logic [RW-1:0] fifoInData [NS], fifoOutData [NS];
    logic [IW-1:0] fifoWrIdx [NS], fifoRdIdx [NS];
    logic [NS-1:0] rdFifoHit, rdStatHit, wrQueueHit, ovfSet, unfSet;
    logic [BW-1:0] fifoWord [NS], statPart [NS];

    // sequencer engine
    asq_pkg::asq_state_e state_r, stateNxt;
    logic [1:0] seq_r, seqNxt;
    logic [asq_pkg::STEP_W-1:0] step_r, stepNxt;
    logic [NS-1:0] startClr, rawIrq_r;
    logic convReq_r, reqGo, engPush, lastSample;
    asq_pkg::asq_conv_s conv_r;
    asq_pkg::asq_nibble_s curNib;
    assign curNib = (seq_r == asq_pkg::SEQ_SINGLE) ? seq3Nib : ctl0Nibs[step_r];
    assign reqGo = (state_r == asq_pkg::ST_REQ) & fifoInReady[seq_r];
    assign engPush = (state_r == asq_pkg::ST_WAIT) & convDone;
    assign lastSample = curNib.last
                        | (step_r == asq_pkg::STEP_W'(asq_pkg::NUM_SAMPLES - 1));

    for (genvar k = 0; k < NS; k++) begin : gSeq
        logic fromEngine;
        logic fromExt;
        logic [PW-1:0] wrIdxPad;
        logic [PW-1:0] rdIdxPad;

        assign fromEngine = engPush & (seq_r == 2'(k));
        assign fromExt = extValid & (extSeq == 2'(k))
                         & ((2'(k) == asq_pkg::SEQ_EXT_A) | (2'(k) == asq_pkg::SEQ_EXT_B));
        assign fifoInValid[k] = fromEngine | fromExt;
        assign fifoInData[k] = fromEngine ? convData : extData;
        assign ovfSet[k] = fifoInValid[k] & ~fifoInReady[k];
        assign rdFifoHit[k] = hitOff(araddr, asq_pkg::OFF_FIFO[k]);
        assign rdStatHit[k] = hitOff(araddr, asq_pkg::OFF_FSTAT[k]);
        assign wrQueueHit[k] = hitOff(wrAddr_r, asq_pkg::OFF_FIFO[k])
                               | hitOff(wrAddr_r, asq_pkg::OFF_FSTAT[k]);
        assign fifoOutReady[k] = arTake & rdFifoHit[k];
        assign unfSet[k] = fifoOutReady[k] & ~fifoOutValid[k];
        assign wrIdxPad = PW'(fifoWrIdx[k]);
        assign rdIdxPad = PW'(fifoRdIdx[k]);
        assign fifoWord[k] = (rdFifoHit[k] & fifoOutValid[k])
                             ? BW'(fifoOutData[k]) : '0;
        assign statPart[k] = rdStatHit[k]
                             ? statWord(fifoFull[k], fifoEmpty[k], wrIdxPad, rdIdxPad)
                             : '0;

        asq_fifo #(
            .WIDTH(RW),
            .DEPTH(FIFO_DEPTH),
            .IW(IW)
        ) uFifo (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .inValid(fifoInValid[k]),
            .inReady(fifoInReady[k]),
            .inData(fifoInData[k]),
            .outValid(fifoOutValid[k]),
            .outReady(fifoOutReady[k]),
            .outData(fifoOutData[k]),
            .wrIdx(fifoWrIdx[k]),
            .rdIdx(fifoRdIdx[k]),
            .full(fifoFull[k]),
            .empty(fifoEmpty[k])
        );
    end

    // read selection
    logic rdCtl0, rdSeq3, rdOvf, rdUnf, rdTrig, rdHit;
    logic [BW-1:0] qPart, rdMux, trigWord;
    assign rdCtl0 = hitOff(araddr, asq_pkg::OFF_SEQ0_CTL);
    assign rdSeq3 = hitOff(araddr, asq_pkg::OFF_SEQ3_CTL);
    assign rdOvf = hitOff(araddr, asq_pkg::OFF_OVF);
    assign rdUnf = hitOff(araddr, asq_pkg::OFF_UNF);
    assign rdTrig = hitOff(araddr, asq_pkg::OFF_TRIG);
    assign rdHit = rdCtl0 | rdSeq3 | rdOvf | rdUnf | rdTrig | (|rdFifoHit) | (|rdStatHit);
    assign wrHit = wrCtl0 | wrSeq3 | wrOvf | wrUnf | wrTrig | (doWrite & (|wrQueueHit));

    always_comb begin
        trigWord = BW'(pending_r);
        trigWord[asq_pkg::TRIG_BUSY_BIT] = (state_r != asq_pkg::ST_IDLE);
        qPart = '0;
        for (int k = 0; k < NS; k++) begin
            qPart = qPart | fifoWord[k] | statPart[k];
        end
    end

    assign rdMux = qPart
                   | (rdCtl0 ? ctl0_r : '0)
                   | (rdSeq3 ? BW'(seq3Nib) : '0)
                   | (rdOvf ? BW'(ovf_r) : '0)
                   | (rdUnf ? BW'(unf_r) : '0)
                   | (rdTrig ? trigWord : '0);

    // engine next state
    always_comb begin
        stateNxt = state_r;
        seqNxt = seq_r;
        stepNxt = step_r;
        startClr = '0;
        case (state_r)
            asq_pkg::ST_IDLE: begin
                if (pending_r[asq_pkg::SEQ_FULL]) begin
                    seqNxt = asq_pkg::SEQ_FULL;
                    stepNxt = '0;
                    startClr[asq_pkg::SEQ_FULL] = 1'b1;
                    stateNxt = asq_pkg::ST_REQ;
                end else if (pending_r[asq_pkg::SEQ_SINGLE]) begin
                    seqNxt = asq_pkg::SEQ_SINGLE;
                    stepNxt = '0;
                    startClr[asq_pkg::SEQ_SINGLE] = 1'b1;
                    stateNxt = asq_pkg::ST_REQ;
                end
            end
            asq_pkg::ST_REQ: begin
                if (reqGo) begin
                    stateNxt = asq_pkg::ST_WAIT;
                end
            end
            asq_pkg::ST_WAIT: begin
                if (convDone) begin
                    if (lastSample) begin
                        stateNxt = asq_pkg::ST_IDLE;
                    end else begin
                        stepNxt = asq_pkg::STEP_W'(step_r + 1'b1);
                        stateNxt = asq_pkg::ST_REQ;
                    end
                end
            end
            default: begin
                stateNxt = asq_pkg::ST_IDLE;
            end
        endcase
    end

    // bus handshake registers
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= asq_pkg::RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= asq_pkg::RESP_OKAY;
            rdata_r <= '0;
        end else begin
            awHave_r <= awHaveNxt;
            wHave_r <= wHaveNxt;
            awready_r <= ~awHaveNxt;
            wready_r <= ~wHaveNxt;
            bvalid_r <= doWrite | (bvalid_r & ~bready);
            bresp_r <= doWrite ? (wrHit ? asq_pkg::RESP_OKAY : asq_pkg::RESP_SLVERR) : bresp_r;
            arready_r <= ~rvalidNxt;
            rvalid_r <= rvalidNxt;
            rresp_r <= arTake ? (rdHit ? asq_pkg::RESP_OKAY : asq_pkg::RESP_SLVERR) : rresp_r;
            rdata_r <= arTake ? rdMux : rdata_r;
        end
    end

    always_ff @(posedge core_clk) begin
        wrAddr_r <= awTake ? awaddr : wrAddr_r;
        wrData_r <= wTake ? wdata : wrData_r;
        wrStrb_r <= wTake ? wstrb : wrStrb_r;
    end

    // software registers and sticky flags; a set wins over a clear
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ctl0_r <= asq_pkg::CTL0_RESET;
            seq3Ctl_r <= asq_pkg::SEQ3_CTL_RESET;
            ovf_r <= '0;
            unf_r <= '0;
            pending_r <= '0;
        end else begin
            ctl0_r <= wrCtl0 ? strbMerge(ctl0_r, wrData_r, wrStrb_r) : ctl0_r;
            seq3Ctl_r <= (wrSeq3 & wrStrb_r[0]) ? wrData_r[3:0] : seq3Ctl_r;
            ovf_r <= (ovf_r & ~(wrOvf ? lowByte : '0)) | ovfSet;
            unf_r <= (unf_r & ~(wrUnf ? lowByte : '0)) | unfSet;
            pending_r <= (pending_r & ~startClr)
                         | ((wrTrig ? lowByte : '0) & asq_pkg::ENGINE_SEQ_MASK);
        end
    end

    // engine registers
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_r <= asq_pkg::ST_IDLE;
            seq_r <= asq_pkg::SEQ_FULL;
            step_r <= '0;
            convReq_r <= 1'b0;
            conv_r <= '0;
            rawIrq_r <= '0;
        end else begin
            state_r <= stateNxt;
            seq_r <= seqNxt;
            step_r <= stepNxt;
            convReq_r <= reqGo | (convReq_r & ~engPush);
            if (reqGo) begin
                conv_r.seq <= seq_r;
                conv_r.step <= step_r;
                conv_r.tempSel <= curNib.tempSel;
                conv_r.diffSel <= curNib.diffSel & ~curNib.tempSel;
            end
            rawIrq_r <= (engPush & curNib.irqEn) ? (NS'(1) << seq_r) : '0;
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign convReq = convReq_r;
    assign convCmd = conv_r;
    assign rawIrq = rawIrq_r;
    assign ovfFlags = ovf_r;
    assign unfFlags = unf_r;
endmodule

// File: asq_pkg.sv
// Purpose: shared constants and types for the sample sequence control and result FIFOs
// Assumes: 32-bit register bus, byte addresses in the low eight address bits
// Notes: word offsets are byte addresses; bits 1:0 of an address are ignored
package asq_pkg;
    // sizes
    localparam int ADDR_W = 8;
    localparam int BUS_W = 32;
    localparam int RES_W = 10;
    localparam int NUM_SEQ = 4;
    localparam int NUM_SAMPLES = 8;
    localparam int STEP_W = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 4;
    localparam int STRB_W = 4;

    // register offsets
    localparam logic [ADDR_W-1:0] OFF_OVF = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_UNF = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_TRIG = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_SEQ0_CTL = 8'h44;
    localparam logic [ADDR_W-1:0] OFF_SEQ3_CTL = 8'hA4;
    localparam logic [NUM_SEQ-1:0][ADDR_W-1:0] OFF_FIFO = {8'hA8, 8'h88, 8'h68, 8'h48};
    localparam logic [NUM_SEQ-1:0][ADDR_W-1:0] OFF_FSTAT = {8'hAC, 8'h8C, 8'h6C, 8'h4C};

    // reset values
    localparam logic [BUS_W-1:0] CTL0_RESET = 32'h0000_0000;
    localparam logic [3:0] SEQ3_CTL_RESET = 4'h0;
    localparam logic [BUS_W-1:0] FSTAT_RESET = 32'h0000_0100;

    // status word layout
    localparam int STAT_FULL_BIT = 12;
    localparam int STAT_EMPTY_BIT = 8;
    localparam int STAT_WR_LSB = 4;
    localparam int STAT_RD_LSB = 0;
    localparam int TRIG_BUSY_BIT = 8;

    // sequencer roles
    localparam logic [1:0] SEQ_FULL = 2'h0;
    localparam logic [1:0] SEQ_EXT_A = 2'h1;
    localparam logic [1:0] SEQ_EXT_B = 2'h2;
    localparam logic [1:0] SEQ_SINGLE = 2'h3;
    localparam logic [NUM_SEQ-1:0] ENGINE_SEQ_MASK = 4'h9;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one sample's control nibble, msb first
    typedef struct packed {
        logic tempSel;
        logic irqEn;
        logic last;
        logic diffSel;
    } asq_nibble_s;

    // request presented to the converter
    typedef struct packed {
        logic [1:0] seq;
        logic [STEP_W-1:0] step;
        logic tempSel;
        logic diffSel;
    } asq_conv_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_REQ = 3'h2,
        ST_WAIT = 3'h4
    } asq_state_e;
endpackage

// File: asq_fifo.sv
// Purpose: result FIFO with valid/ready on both sides and pointer visibility
// Assumes: DEPTH is a power of two, at least two
// Notes: read data is the head entry, valid whenever outValid is high
`timescale 1ns/100ps
module asq_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8,
    parameter int IW = $clog2(DEPTH)
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    // visibility
    output logic [IW-1:0] wrIdx,
    output logic [IW-1:0] rdIdx,
    output logic full,
    output logic empty
);
    if (DEPTH < 2 || (1 << IW) != DEPTH || WIDTH < 1) begin : gBadParam
        $error("asq_fifo: DEPTH must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [IW-1:0] wrPtr_r;
    logic [IW-1:0] rdPtr_r;
    logic [IW:0] count_r;
    logic push;
    logic pop;

    assign full = (count_r == (IW+1)'(DEPTH));
    assign empty = (count_r == '0);
    assign inReady = ~full;
    assign outValid = ~empty;
    assign push = inValid & inReady;
    assign pop = outValid & outReady;
    assign outData = mem[rdPtr_r];
    assign wrIdx = wrPtr_r;
    assign rdIdx = rdPtr_r;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            wrPtr_r <= push ? IW'(wrPtr_r + 1'b1) : wrPtr_r;
            rdPtr_r <= pop ? IW'(rdPtr_r + 1'b1) : rdPtr_r;
            count_r <= (IW+1)'(count_r + {{IW{1'b0}}, push} - {{IW{1'b0}}, pop});
        end
    end
endmodule

// File: asq_seq_ctrl_sva.sv
// Purpose: port checks on the sequence controller
// Assumes: one clock domain, rst_b synchronous active low
// Notes: attached by bind to every controller instance
`timescale 1ns/100ps
module asq_seq_ctrl_sva #(
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // read channel
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    // converter
    input wire asq_pkg::asq_conv_s convCmd,
    input wire logic convReq,
    input wire logic convDone,
    input wire logic [3:0] rawIrq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence convEnd;
        convReq && convDone;
    endsequence
    rd_answer_a:
        assert property (arvalid && arready |=> rvalid) else $error("read answer late");
    rd_drop_a:
        assert property (rvalid && rready |=> !rvalid) else $error("read data held");
    rd_block_a:
        assert property (rvalid |-> !arready) else $error("second read open");
    irq_cause_a:
        assert property (rawIrq[0] |-> $past(convReq && convDone)) else $error("stray irq");
    cmd_hold_a:
        assert property (convReq && !convDone |=> convReq && $stable(convCmd))
        else $error("request moved");
    req_drop_a:
        assert property (convEnd |=> !convReq) else $error("request held");
    temp_diff_a:
        assert property (convReq && convCmd.tempSel |-> !convCmd.diffSel)
        else $error("sensor differential");
    single_step_a:
        assert property (convReq && convCmd.seq == 2'h3 |-> convCmd.step == 3'h0)
        else $error("single sequencer stepped");
endmodule

bind asq_seq_ctrl asq_seq_ctrl_sva #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.core_clk, .rst_b, .arvalid,
    .arready, .rvalid, .rready, .convCmd, .convReq, .convDone, .rawIrq);

// File: test_asq_seq_ctrl.sv
// Purpose: self-checking bench for the sequence controller
// Assumes: converter answers one cycle after each request
// Notes: random words from an lfsr seeded at 12582
`timescale 1ns/100ps
module test_asq_seq_ctrl;
    logic core_clk = 1'h0, rst_b = 1'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, ctlW = 32'h0, v;
    logic [3:0] wstrb = 4'hF, rawIrq, ovfFlags, unfFlags, ctl3 = 4'h0, nb;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1, arvalid = 1'h0, rready = 1'h1;
    logic awready, wready, bvalid, arready, rvalid, convReq, convDone = 1'h0, extValid = 1'h0;
    logic [1:0] bresp, rresp, r, extSeq = 2'h0;
    logic [9:0] convData = 10'h0, extData = 10'h0;
    logic [15:0] seed = 16'h3126, cs = 16'h3126;
    asq_pkg::asq_conv_s convCmd;
    logic [9:0] q[4][$];
    int fail_count = 0, compares = 0, stepCnt = 0, irqCnt = 0, p, tot = 0;
    asq_seq_ctrl DUT (.core_clk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .convCmd, .convReq, .convDone, .convData, .extValid, .extSeq, .extData,
        .rawIrq, .ovfFlags, .unfFlags);
    always #10 core_clk = ~core_clk;
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic int irqs(input logic [31:0] w, input int n);
        int c;
        c = 0;
        for (int i = 0; i <= n; i++) c += w[4*i+2];
        return c;
    endfunction
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic conclude();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!bvalid);
        cmp("bresp", asq_pkg::RESP_OKAY, bresp);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
        araddr <= a;
        arvalid <= 1'h1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        s = rresp;
    endtask
    task automatic run(input logic [31:0] trig, input int n, input int irq);
        stepCnt = 0;
        irqCnt = 0;
        wr(asq_pkg::OFF_TRIG, trig);
        for (int i = 0; i < 300 && stepCnt < n; i++) @(posedge core_clk);
        repeat (20) @(posedge core_clk);
        cmp("steps", n, stepCnt);
        cmp("irqs", irq, irqCnt);
    endtask
    // converter stand-in answering each request one cycle later
    always @(posedge core_clk) begin
        convDone <= convReq && !convDone;
        cs <= lfsr(cs);
        convData <= cs[9:0];
        irqCnt += $countones(rawIrq);
        if (convReq && convDone) begin
            nb = convCmd.seq == 2'h3 ? ctl3 : ctlW[convCmd.step*4 +: 4];
            cmp("step", stepCnt, convCmd.step);
            cmp("temp", nb[3], convCmd.tempSel);
            cmp("diff", nb[0] & ~nb[3], convCmd.diffSel);
            q[convCmd.seq].push_back(convData);
            stepCnt++;
        end
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'h1;
        @(posedge core_clk);
        for (int i = 0; i < 4; i++) begin
            rd(asq_pkg::OFF_FSTAT[i], v, r);
            cmp("stat", 32'h100, v);
        end
        rd(asq_pkg::OFF_SEQ0_CTL, v, r);
        cmp("ctl0", 32'h0, v);
        rd(asq_pkg::OFF_SEQ3_CTL, v, r);
        cmp("ctl3", 32'h2, v);
        rd(8'h04, v, r);
        cmp("resp", asq_pkg::RESP_SLVERR, r);
        for (int it = 0; it < 3; it++) begin
            seed = lfsr(lfsr(seed));
            p = it == 0 ? 7 : it == 1 ? 0 : seed[2:0];
            ctlW = {seed, lfsr(seed)} & 32'hDDDD_DDDD | 32'h2000_0000 | (32'h2 << 4*p);
            wr(asq_pkg::OFF_SEQ0_CTL, ctlW);
            rd(asq_pkg::OFF_SEQ0_CTL, v, r);
            cmp("ctl0", ctlW, v);
            run(32'h1, p + 1, irqs(ctlW, p));
            for (int i = 0; i <= p; i++) begin
                rd(8'h48, v, r);
                cmp("fifo0", {22'h0, q[0].pop_front()}, v);
            end
            tot += p + 1;
            rd(8'h4C, v, r);
            cmp("stat0", 32'h100 | (tot % 8) * 32'h11, v);
        end
        rd(8'h48, v, r);
        cmp("empty", 32'h0, v);
        repeat (2) @(posedge core_clk);
        cmp("unf", 32'h1, unfFlags);
        rd(8'h4C, v, r);
        cmp("stat0", 32'h100 | (tot % 8) * 32'h11, v);
        wr(asq_pkg::OFF_UNF, 32'h1);
        repeat (2) @(posedge core_clk);
        cmp("unf", 32'h0, unfFlags);
        ctl3 = 4'hF;
        wr(asq_pkg::OFF_SEQ3_CTL, 32'hD);
        rd(asq_pkg::OFF_SEQ3_CTL, v, r);
        cmp("ctl3", 32'hF, v);
        run(32'h8, 1, 1);
        rd(8'hA8, v, r);
        cmp("fifo3", {22'h0, q[3].pop_front()}, v);
        rd(asq_pkg::OFF_TRIG, v, r);
        cmp("trig", 32'h0, v);
        // nine results into a depth-eight fifo, then one for sequencer 2
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            @(posedge core_clk);
            extValid <= 1'h1;
            extSeq <= i == 9 ? 2'h2 : 2'h1;
            extData <= seed[9:0];
            if (i != 8) q[i == 9 ? 2 : 1].push_back(seed[9:0]);
            @(posedge core_clk);
            extValid <= 1'h0;
        end
        repeat (2) @(posedge core_clk);
        cmp("ovf", 32'h2, ovfFlags);
        rd(8'h6C, v, r);
        cmp("stat1", 32'h1000, v);
        for (int i = 0; i < 8; i++) begin
            rd(8'h68, v, r);
            cmp("fifo1", {22'h0, q[1].pop_front()}, v);
        end
        rd(8'h88, v, r);
        cmp("fifo2", {22'h0, q[2].pop_front()}, v);
        wr(asq_pkg::OFF_OVF, 32'h2);
        repeat (2) @(posedge core_clk);
        cmp("ovf", 32'h0, ovfFlags);
        conclude();
    end
endmodule
